// >>> src/tbd_crc.sv
// Purpose: one-byte step of the 16-bit reflected block CRC
// Assumes: bytes enter least significant bit first
// Notes:   purely combinational
`timescale 1ns/1ps
`include "tbd_params.svh"
module tbd_crc (
  input  logic [15:0] crc_in,
  input  logic [7:0]  data,
  output logic [15:0] crc_out
);
  logic [15:0] c;

  always_comb begin
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `TBD_CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end
endmodule : tbd_crc

// >>> src/tbd_dispatch.sv
// Purpose: first-byte dispatch of level-4 blocks and vendor commands
// Assumes: framer strips block CRC and flags parity/CRC faults on RX_LAST;
//          EEPROM read data is valid in the same cycle as EE_RD
// Notes:   ATS bytes are sent by the framer on ATS_REQ
// Operation
// - vendor prologue 01, b6=0 b5=1 b3=1 b2=0 b1=1
// - prologue b4 set means identifier byte follows
// - wake-up 01h raises interrupt, echoes 01h
// - word address is address byte upper seven bits
// - good read answers 90h then word data
// - more than eight words returns first eight
// - read-locked words read back as zeros
// - words past the end read as zeros
// - read from nonexistent start answers 61h only
// - power check first; failure answers 64h, no write
// - write reply waits until programming completes
// - write status 90h, 61h, 62h or 64h; errors skip
// - active after select; classify every block's first byte
// - E0h answered with ATS only as first block
// - 1101 answered with PPS only after RATS
// - 1100x010 answered, then tag halts
// - 00, 10 and 1111 blocks go to FIFO
// - late RATS or PPS go to FIFO untouched
// - 01xx xxxx blocks executed, never forwarded
// - executed blocks with wrong identifier are ignored
`timescale 1ns/1ps
`include "tbd_params.svh"
module tbd_dispatch #(
  parameter int unsigned PROG_CYCLES = `TBD_PROG_CYC,
  parameter int unsigned PCW         = $clog2(PROG_CYCLES + 1)
) (
  input  logic        MCLK,
  input  logic        RST,
  input  logic        ENTER_ACTIVE,
  input  logic        RX_VALID,
  input  logic [7:0]  RX_DATA,
  input  logic        RX_LAST,
  input  logic        RX_ERR,
  output logic        FIFO_VALID,
  output logic [7:0]  FIFO_DATA,
  output logic        FIFO_LAST,
  output logic        TX_VALID,
  output logic [7:0]  TX_DATA,
  output logic        TX_LAST,
  input  logic        TX_READY,
  output logic        ATS_REQ,
  output logic        GO_HALT,
  output logic        WAKE_IRQ,
  output logic [3:0]  ASSIGNED_CID,
  output logic        EE_RD,
  output logic [4:0]  EE_ADDR,
  input  logic [31:0] EE_RDATA,
  output logic        EE_PCHK,
  input  logic        EE_PCHK_DONE,
  input  logic        EE_PCHK_OK,
  output logic        EE_WR,
  output logic [31:0] EE_WDATA,
  input  logic [31:0] RD_LOCK,
  input  logic [31:0] WR_LOCK
);
  import tbd_pkg::*;

  tbd_tag_e    tag_st,    next_tag_st;
  tbd_blk_e    st,        next_st;
  tbd_txp_e    txp,       next_txp;
  tbd_exe_e    exe,       next_exe;
  logic [7:0]  rxb [8],   next_rxb [8];
  logic [31:0] rbuf [8],  next_rbuf [8];
  logic [3:0]  rx_cnt,    next_rx_cnt;
  logic        rx_err,    next_rx_err;
  logic [3:0]  cid,       next_cid;
  logic [7:0]  status,    next_status;
  logic [6:0]  rd_a,      next_rd_a;
  logic [3:0]  rd_i,      next_rd_i;
  logic [3:0]  rd_n,      next_rd_n;
  logic        rd_zero,   next_rd_zero;
  logic        is_read,   next_is_read;
  logic        halt_pend, next_halt_pend;
  logic [5:0]  body_idx,  next_body_idx;
  logic [5:0]  body_len,  next_body_len;
  logic [15:0] crc,       next_crc;
  logic [PCW-1:0] prog_cnt, next_prog_cnt;
  logic [7:0]  tx_data,   next_tx_data;
  logic        fifo_valid, next_fifo_valid;
  logic [7:0]  fifo_data, next_fifo_data;
  logic        fifo_last, next_fifo_last;
  logic        ats_req,   next_ats_req;
  logic        go_halt,   next_go_halt;
  logic        wake_irq,  next_wake_irq;
  logic        ee_rd,     next_ee_rd;
  logic [4:0]  ee_addr,   next_ee_addr;
  logic        ee_pchk,   next_ee_pchk;
  logic        ee_wr,     next_ee_wr;
  logic [31:0] ee_wdata,  next_ee_wdata;

  logic        has_cid;
  logic [2:0]  off;
  logic [3:0]  ninf;
  logic [7:0]  cmd;
  logic [6:0]  waddr;
  logic [7:0]  nreq;
  logic        cid_ok;
  logic        go_tx;
  logic [15:0] crc_step;
  logic [5:0]  bi;
  logic [5:0]  bm;
  logic [7:0]  body_byte;
  logic [5:0]  wa;
  logic [2:0]  rd_slot;

  // vendor layout: prologue, optional identifier, then information field
  assign has_cid = rxb[0][`TBD_CID_BIT];
  assign off     = has_cid ? 3'd2 : 3'd1;
  assign ninf    = rx_cnt - {1'b0, off};
  assign cmd     = rxb[off];
  assign waddr   = rxb[3'(off + 3'd1)][7:1];
  assign nreq    = rxb[3'(off + 3'd2)];
  assign cid_ok  = !has_cid || (rxb[1][3:0] == cid);
  assign rd_slot = rd_i[2:0];
  assign wa      = {1'b0, rd_a[4:0]} + {2'b00, rd_i};

  // reply body: status byte, then read words least significant byte first
  assign bi        = (txp == P_BODY) ? body_idx + 6'd1 : 6'd0;
  assign bm        = bi - 6'd1;
  assign body_byte = (bi == 6'd0) ? status : rbuf[bm[4:2]][{bm[1:0], 3'b000} +: 8];

  tbd_crc u_crc (
    .crc_in  (crc),
    .data    (tx_data),
    .crc_out (crc_step)
  );

  always_comb begin
    next_tag_st = tag_st;       next_st       = st;        next_txp       = txp;
    next_exe    = exe;          next_rxb      = rxb;       next_rbuf      = rbuf;
    next_rx_cnt = rx_cnt;       next_rx_err   = rx_err;    next_cid       = cid;
    next_status = status;       next_rd_a     = rd_a;      next_rd_i      = rd_i;
    next_rd_n   = rd_n;         next_rd_zero  = rd_zero;   next_is_read   = is_read;
    next_halt_pend = halt_pend; next_body_idx = body_idx;  next_body_len  = body_len;
    next_crc    = crc;          next_prog_cnt = prog_cnt;  next_tx_data   = tx_data;
    next_fifo_data = fifo_data; next_ee_addr  = ee_addr;   next_ee_wdata  = ee_wdata;
    next_fifo_valid = 1'b0;     next_fifo_last = 1'b0;     next_ats_req   = 1'b0;
    next_go_halt = 1'b0;        next_wake_irq = 1'b0;      next_ee_rd     = 1'b0;
    next_ee_pchk = 1'b0;        next_ee_wr    = 1'b0;      go_tx          = 1'b0;
    unique case (st)
      B_FIRST: begin
        if (RX_VALID && tag_st != TAG_IDLE) begin
          next_rxb[0]  = RX_DATA;
          next_rx_cnt  = 4'd1;
          next_rx_err  = RX_ERR;
          next_is_read = 1'b0;
          next_st      = RX_LAST ? B_EXEC : B_GATHER;
          if (tag_st != TAG_AFTER_RATS || RX_DATA[7:4] != `TBD_PPS_NIB) begin
            next_tag_st = TAG_PROTO;
          end
          if (RX_DATA == `TBD_RATS && tag_st == TAG_FIRST) begin
            next_exe    = X_RATS;
            next_tag_st = TAG_AFTER_RATS;
          end else if (RX_DATA[7:4] == `TBD_PPS_NIB && tag_st == TAG_AFTER_RATS) begin
            next_exe = X_PPS;
          end else if ((RX_DATA & `TBD_DSL_MASK) == `TBD_DSL_PCB) begin
            next_exe = X_DESEL;
          end else if (RX_DATA[7:6] == 2'b01) begin
            next_exe = X_VEND;
          end else begin
            // late RATS/PPS, other S-blocks, I-, R- and 1111 blocks
            next_fifo_valid = 1'b1;
            next_fifo_data  = RX_DATA;
            next_fifo_last  = RX_LAST;
            next_st         = RX_LAST ? B_FIRST : B_FWD;
          end
        end
      end
      B_FWD: begin
        if (RX_VALID) begin
          next_fifo_valid = 1'b1;
          next_fifo_data  = RX_DATA;
          next_fifo_last  = RX_LAST;
          if (RX_LAST) begin
            next_st = B_FIRST;
          end
        end
      end
      B_GATHER: begin
        if (RX_VALID) begin
          if (rx_cnt < `TBD_RX_KEEP) begin
            next_rxb[rx_cnt[2:0]] = RX_DATA;
          end
          if (rx_cnt != 4'hf) begin
            next_rx_cnt = rx_cnt + 4'd1;
          end
          next_rx_err = rx_err | RX_ERR;
          if (RX_LAST) begin
            next_st = B_EXEC;
          end
        end
      end
      B_EXEC: begin
        next_st     = B_FIRST;
        next_status = `TBD_ST_ERR;
        unique case (exe)
          X_RATS: begin
            if (!rx_err && rx_cnt >= 4'd2) begin
              next_cid     = rxb[1][3:0];
              next_ats_req = 1'b1;
            end
          end
          X_PPS: begin
            if (!rx_err && rx_cnt >= 4'd2 && rxb[1][3:0] == cid) begin
              next_body_len = 6'd0;
              next_tag_st   = TAG_PROTO;
              go_tx         = 1'b1;
            end
          end
          X_DESEL: begin
            if (!rx_err && cid_ok) begin
              next_body_len  = 6'd0;
              next_halt_pend = 1'b1;
              go_tx          = 1'b1;
            end
          end
          X_VEND: begin
            if (((rxb[0] & `TBD_VND_MASK) == `TBD_VND_PCB) && cid_ok) begin
              next_body_len = 6'd1;
              go_tx         = 1'b1;
              if (rx_err) begin
                next_status = `TBD_ST_ERR;
              end else if (cmd == `TBD_CMD_WAKE && ninf == `TBD_LEN_WAKE) begin
                next_status   = `TBD_CMD_WAKE;
                next_wake_irq = 1'b1;
              end else if (cmd == `TBD_CMD_READ && ninf == `TBD_LEN_READ) begin
                if (waddr <= `TBD_LAST_WORD) begin
                  go_tx        = 1'b0;
                  next_status  = `TBD_ST_OK;
                  next_rd_a    = waddr;
                  next_rd_i    = 4'd0;
                  next_rd_n    = (nreq > `TBD_READ_MAX) ? 4'(`TBD_READ_MAX) : nreq[3:0];
                  next_st      = B_RFETCH;
                end
              end else if (cmd == `TBD_CMD_WRITE && ninf == `TBD_LEN_WRITE) begin
                if (waddr > `TBD_LAST_WORD) begin
                  next_status = `TBD_ST_ERR;
                end else if (waddr < `TBD_RO_WORDS || WR_LOCK[waddr[4:0]]) begin
                  next_status = `TBD_ST_LOCK;
                end else begin
                  go_tx         = 1'b0;
                  next_ee_addr  = waddr[4:0];
                  next_ee_wdata = {rxb[3'(off + 3'd5)], rxb[3'(off + 3'd4)],
                                   rxb[3'(off + 3'd3)], rxb[3'(off + 3'd2)]};
                  next_ee_pchk  = 1'b1;
                  next_st       = B_PCHK;
                end
              end
            end
          end
        endcase
      end
      B_RFETCH: begin
        if (rd_i == rd_n) begin
          next_is_read  = 1'b1;
          next_body_len = {rd_n, 2'b00} + 6'd1;
          go_tx         = 1'b1;
        end else begin
          // past the end or read-locked: no access, zeros instead
          next_rd_zero = (wa > 6'(`TBD_LAST_WORD)) || RD_LOCK[wa[4:0]];
          next_ee_rd   = !next_rd_zero;
          next_ee_addr = wa[4:0];
          next_st      = B_RCAP;
        end
      end
      B_RCAP: begin
        next_rbuf[rd_slot] = rd_zero ? 32'h0000_0000 : EE_RDATA;
        next_rd_i          = rd_i + 4'd1;
        next_st            = B_RFETCH;
      end
      B_PCHK: begin
        if (EE_PCHK_DONE) begin
          if (EE_PCHK_OK) begin
            next_ee_wr    = 1'b1;
            next_prog_cnt = PCW'(PROG_CYCLES - 1);
            next_st       = B_PROG;
          end else begin
            next_status   = `TBD_ST_PWR;
            next_body_len = 6'd1;
            go_tx         = 1'b1;
          end
        end
      end
      B_PROG: begin
        if (prog_cnt == '0) begin
          next_status   = `TBD_ST_OK;
          next_body_len = 6'd1;
          go_tx         = 1'b1;
        end else begin
          next_prog_cnt = prog_cnt - PCW'(1);
        end
      end
      B_TX: begin
        if (TX_READY) begin
          unique case (txp)
            P_PCB, P_CID, P_BODY: begin
              next_crc = crc_step;
              if (txp == P_PCB && has_cid && exe != X_PPS) begin
                next_txp     = P_CID;
                next_tx_data = rxb[1];
              end else if (txp == P_BODY && bi == body_len) begin
                next_txp     = P_CRC1;
                next_tx_data = crc_step[7:0];
              end else if (txp != P_BODY && body_len == 6'd0) begin
                next_txp     = P_CRC1;
                next_tx_data = crc_step[7:0];
              end else begin
                next_body_idx = bi;
                next_txp      = P_BODY;
                next_tx_data  = body_byte;
              end
            end
            P_CRC1: begin
              next_txp     = P_CRC2;
              next_tx_data = crc[15:8];
            end
            P_CRC2: begin
              next_st = B_FIRST;
              if (halt_pend) begin
                next_halt_pend = 1'b0;
                next_go_halt   = 1'b1;
                next_tag_st    = TAG_IDLE;
              end
            end
          endcase
        end
      end
    endcase
    if (go_tx) begin
      next_st       = B_TX;
      next_txp      = P_PCB;
      next_tx_data  = rxb[0];
      next_body_idx = 6'd0;
      next_crc      = `TBD_CRC_INIT;
    end
    if (ENTER_ACTIVE) begin
      next_tag_st = TAG_FIRST;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tag_st <= TAG_IDLE;   st <= B_FIRST;        txp <= P_PCB;     exe <= X_VEND;
      for (int i = 0; i < 8; i++) begin
        rxb[i]  <= 8'h00;
        rbuf[i] <= 32'h0000_0000;
      end
      rx_cnt <= 4'h0;       rx_err <= 1'b0;       cid <= 4'h0;      status <= 8'h00;
      rd_a <= 7'h00;        rd_i <= 4'h0;         rd_n <= 4'h0;     rd_zero <= 1'b0;
      is_read <= 1'b0;      halt_pend <= 1'b0;    body_idx <= 6'h00; body_len <= 6'h00;
      crc <= 16'h0000;      prog_cnt <= '0;       tx_data <= 8'h00; fifo_valid <= 1'b0;
      fifo_data <= 8'h00;   fifo_last <= 1'b0;    ats_req <= 1'b0;  go_halt <= 1'b0;
      wake_irq <= 1'b0;     ee_rd <= 1'b0;        ee_addr <= 5'h00; ee_pchk <= 1'b0;
      ee_wr <= 1'b0;        ee_wdata <= 32'h0000_0000;
    end else begin
      tag_st <= next_tag_st; st <= next_st;       txp <= next_txp;  exe <= next_exe;
      rxb <= next_rxb;       rbuf <= next_rbuf;
      rx_cnt <= next_rx_cnt; rx_err <= next_rx_err; cid <= next_cid; status <= next_status;
      rd_a <= next_rd_a;     rd_i <= next_rd_i;   rd_n <= next_rd_n; rd_zero <= next_rd_zero;
      is_read <= next_is_read; halt_pend <= next_halt_pend;
      body_idx <= next_body_idx; body_len <= next_body_len;
      crc <= next_crc;       prog_cnt <= next_prog_cnt; tx_data <= next_tx_data;
      fifo_valid <= next_fifo_valid; fifo_data <= next_fifo_data; fifo_last <= next_fifo_last;
      ats_req <= next_ats_req; go_halt <= next_go_halt; wake_irq <= next_wake_irq;
      ee_rd <= next_ee_rd;   ee_addr <= next_ee_addr; ee_pchk <= next_ee_pchk;
      ee_wr <= next_ee_wr;   ee_wdata <= next_ee_wdata;
    end
  end

  assign FIFO_VALID   = fifo_valid;
  assign FIFO_DATA    = fifo_data;
  assign FIFO_LAST    = fifo_last;
  assign TX_VALID     = (st == B_TX);
  assign TX_DATA      = tx_data;
  assign TX_LAST      = (st == B_TX) && (txp == P_CRC2);
  assign ATS_REQ      = ats_req;
  assign GO_HALT      = go_halt;
  assign WAKE_IRQ     = wake_irq;
  assign ASSIGNED_CID = cid;
  assign EE_RD        = ee_rd;
  assign EE_ADDR      = ee_addr;
  assign EE_PCHK      = ee_pchk;
  assign EE_WR        = ee_wr;
  assign EE_WDATA     = ee_wdata;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  logic first_act;
  assign first_act = (st == B_FIRST) && RX_VALID && (tag_st != TAG_IDLE);

  a_fifo_pass: assert property (first_act && (RX_DATA[7:6] == 2'b00 || RX_DATA[7:6] == 2'b10
      || RX_DATA[7:4] == 4'hf) |=> FIFO_VALID && FIFO_DATA == $past(RX_DATA))
    else $error("forwarded block byte missing from fifo");
  a_vendor_kept: assert property (first_act && RX_DATA[7:6] == 2'b01 |=> !FIFO_VALID)
    else $error("vendor block leaked to fifo");
  a_late_rats: assert property (first_act && RX_DATA == 8'he0 && tag_st == TAG_PROTO
      |=> FIFO_VALID && !ATS_REQ)
    else $error("late rats was acted upon");
  a_wake_echo: assert property (WAKE_IRQ |-> st == B_TX && status == 8'h01
      && body_len == 6'd1)
    else $error("wake reply not queued with interrupt");
  a_read_cap: assert property (st == B_RFETCH |-> rd_n <= 4'd8 && rd_i <= rd_n)
    else $error("read count above eight words");
  a_lock_zero: assert property (st == B_RCAP && rd_zero
      |=> rbuf[$past(rd_slot)] == 32'h0 && $past(EE_RD) == 1'b0)
    else $error("locked or missing word not zeroed");
  a_power_fail: assert property (st == B_PCHK && EE_PCHK_DONE && !EE_PCHK_OK
      |-> ##1 (st == B_TX && status == 8'h64 && !EE_WR))
    else $error("power check fail not answered with 64h");
  a_prog_quiet: assert property (EE_WR |=> st == B_PROG && !TX_VALID)
    else $error("write reply before programming ended");
  a_halt_desel: assert property (GO_HALT |-> $past(TX_LAST) && $past(TX_READY)
      && tag_st == TAG_IDLE)
    else $error("halt without finished deselect reply");
  a_reply_pcb: assert property (st == B_TX && $past(st) != B_TX |-> TX_DATA == rxb[0])
    else $error("reply does not start with prologue");

  c_wake:  cover property (WAKE_IRQ);
  c_read:  cover property (st == B_TX && is_read && body_len == 6'd33);
  c_write: cover property (st == B_PROG ##1 st == B_TX);
  c_halt:  cover property (GO_HALT);
endmodule : tbd_dispatch

// >>> src/tbd_params.svh
// Purpose: constants for the level-4 block dispatcher of the tag
// Assumes: 20 MHz core clock
// Notes:   bit b1 of a printed byte is bit 0 here
`ifndef TBD_PARAMS_SVH
`define TBD_PARAMS_SVH

`define TBD_VND_MASK    8'hf7
`define TBD_VND_PCB     8'h55
`define TBD_CID_BIT     3
`define TBD_RATS        8'he0
`define TBD_PPS_NIB     4'hd
`define TBD_DSL_MASK    8'hf7
`define TBD_DSL_PCB     8'hc2
`define TBD_CMD_WAKE    8'h01
`define TBD_CMD_READ    8'h02
`define TBD_CMD_WRITE   8'h04
`define TBD_LEN_WAKE    4'h1
`define TBD_LEN_READ    4'h3
`define TBD_LEN_WRITE   4'h6
`define TBD_ST_OK       8'h90
`define TBD_ST_ERR      8'h61
`define TBD_ST_LOCK     8'h62
`define TBD_ST_PWR      8'h64
`define TBD_LAST_WORD   7'h1f
`define TBD_RO_WORDS    7'h02
`define TBD_READ_MAX    8'h08
`define TBD_RX_KEEP     4'h8
`define TBD_CRC_INIT    16'h6363
`define TBD_CRC_POLY    16'h8408
`define TBD_CLK_NS      50
`define TBD_PROG_US     8000
`define TBD_PROG_CYC    (`TBD_PROG_US * 1000 / `TBD_CLK_NS)

`endif

// >>> src/tbd_pkg.sv
// Purpose: state types of the block dispatcher
// Assumes: nothing
// Notes:   none
package tbd_pkg;
  typedef enum logic [1:0] {TAG_IDLE, TAG_FIRST, TAG_AFTER_RATS, TAG_PROTO} tbd_tag_e;
  typedef enum logic [3:0] {
    B_FIRST, B_FWD, B_GATHER, B_EXEC, B_RFETCH, B_RCAP, B_PCHK, B_PROG, B_TX
  } tbd_blk_e;
  typedef enum logic [2:0] {P_PCB, P_CID, P_BODY, P_CRC1, P_CRC2} tbd_txp_e;
  typedef enum logic [1:0] {X_RATS, X_PPS, X_DESEL, X_VEND} tbd_exe_e;
endpackage : tbd_pkg

// >>> test/tag_block_dispatch_and_eeprom_cmds_test.sv
// Purpose: scenario bench of the level-4 block dispatcher
// Assumes: eeprom returns each byte equal to its word address
// Notes:   programming time shortened to 20 cycles
`timescale 1ns/1ps
module tag_block_dispatch_and_eeprom_cmds_test;
  logic        mclk = 0, rst = 1, act = 0, rx_valid = 0, rx_last = 0, rx_err = 0;
  logic [7:0]  rx_data = 0, fifo_data, tx_data;
  logic        fifo_valid, fifo_last, tx_valid, tx_last, tx_ready, ats, halt, wake;
  logic        ee_rd, ee_pchk, ee_wr, pchk_done = 0, pwr_ok = 1, slow = 0;
  logic [3:0]  cid;
  logic [4:0]  ee_addr, wadr;
  logic [31:0] ee_rdata, ee_wdata, wdat, rd_lock = 0, wr_lock = 0;
  logic [7:0]  fq [$];
  int          num_errors = 0, n_checks = 0, cyc = 0, n_ats = 0, n_halt = 0, n_wake = 0;
  int          n_wr = 0, n_flast = 0;
  always #25 mclk = ~mclk;
  tbd_dispatch #(.PROG_CYCLES(20)) i_tbd_dispatch (.MCLK(mclk), .RST(rst),
    .ENTER_ACTIVE(act), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last),
    .RX_ERR(rx_err), .FIFO_VALID(fifo_valid), .FIFO_DATA(fifo_data),
    .FIFO_LAST(fifo_last), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
    .TX_READY(tx_ready), .ATS_REQ(ats), .GO_HALT(halt), .WAKE_IRQ(wake),
    .ASSIGNED_CID(cid), .EE_RD(ee_rd), .EE_ADDR(ee_addr), .EE_RDATA(ee_rdata),
    .EE_PCHK(ee_pchk), .EE_PCHK_DONE(pchk_done), .EE_PCHK_OK(pwr_ok), .EE_WR(ee_wr),
    .EE_WDATA(ee_wdata), .RD_LOCK(rd_lock), .WR_LOCK(wr_lock));
  tbd_reader i_tbd_reader (.MCLK(mclk), .slow(slow), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready));
  // eeprom read data follows the word address within the read cycle
  assign ee_rdata = {4{3'b0, ee_addr}};
  // power check stand-in, events tallied
  always @(posedge mclk) begin
    pchk_done <= ee_pchk;
    if (fifo_valid === 1'b1) fq.push_back(fifo_data);
    if (fifo_valid === 1'b1 && fifo_last === 1'b1) n_flast++;
    if (ats === 1'b1) n_ats++;
    if (halt === 1'b1) n_halt++;
    if (wake === 1'b1) n_wake++;
    if (ee_wr === 1'b1) begin n_wr++; wdat = ee_wdata; wadr = ee_addr; end
    cyc++;
    if (cyc == 20000) begin num_errors++; results(); end
  end
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic [15:0] crc_a(input logic [7:0] b [$], input int n);
    logic [15:0] c;
    c = 16'h6363;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return c;
  endfunction : crc_a
  task automatic send(input logic [7:0] b [$]);
    for (int i = 0; i < b.size(); i++) begin
      rx_valid <= 1'b1;
      rx_data  <= b[i];
      rx_last  <= (i == b.size() - 1);
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : send
  task automatic xfer(input logic [7:0] b [$]);
    int n0, k;
    n0 = i_tbd_reader.n_last;
    k  = 0;
    i_tbd_reader.q.delete();
    send(b);
    while (i_tbd_reader.n_last == n0 && k < 300) begin @(posedge mclk); k++; end
    check(k < 300, 1);
    @(posedge mclk);
  endtask : xfer
  task automatic t_first;
    act <= 1'b1;
    @(posedge mclk);
    act <= 1'b0;
    send('{8'he0, 8'h53});
    check(n_ats, 1);
    check(cid, 4'h3);
    xfer('{8'hd3, 8'h03});
    check(i_tbd_reader.q.size(), 3);
    check(i_tbd_reader.q[0], 8'hd3);
    check(crc_a(i_tbd_reader.q, 1), {i_tbd_reader.q[2], i_tbd_reader.q[1]});
    send('{8'h0a, 8'h11, 8'he0, 8'h50, 8'hd3, 8'hf2, 8'h9c});
    send('{8'he0, 8'h50});
    send('{8'hc8, 8'h03});
    check(n_ats, 1);
    check(fq.size(), 11);
    check(n_flast, 3);
    check({fq[0], fq[6], fq[7], fq[9]}, 32'h0a9ce0c8);
    $display("test first-byte dispatch done");
  endtask : t_first
  task automatic t_wake;
    xfer('{8'h5d, 8'h03, 8'h01});
    check(i_tbd_reader.q.size(), 5);
    check(crc_a(i_tbd_reader.q, 3), {i_tbd_reader.q[4], i_tbd_reader.q[3]});
    check({i_tbd_reader.q[0], i_tbd_reader.q[1], i_tbd_reader.q[2]}, 24'h5d0301);
    check(n_wake, 1);
    send('{8'h5d, 8'h04, 8'h01});
    send('{8'h75, 8'h01});
    repeat (10) @(posedge mclk);
    check(n_wake, 1);
    check(fq.size(), 11);
    $display("test wake-up done");
  endtask : t_wake
  task automatic t_read;
    rd_lock <= 32'h8000_0000;
    xfer('{8'h55, 8'h02, 8'h3d, 8'h04});
    check(i_tbd_reader.q.size(), 20);
    check({i_tbd_reader.q[1], i_tbd_reader.q[2], i_tbd_reader.q[5]}, 24'h901e1e);
    check(i_tbd_reader.q[6], 8'h00);
    check(i_tbd_reader.q[10], 8'h00);
    slow <= 1'b1;
    xfer('{8'h55, 8'h02, 8'h0a, 8'h09});
    check(i_tbd_reader.q.size(), 36);
    check(i_tbd_reader.q[33], 8'h0c);
    check(crc_a(i_tbd_reader.q, 34), {i_tbd_reader.q[35], i_tbd_reader.q[34]});
    slow <= 1'b0;
    xfer('{8'h55, 8'h02, 8'h40, 8'h01});
    check(i_tbd_reader.q.size(), 4);
    check(i_tbd_reader.q[1], 8'h61);
    $display("test eeprom read done");
  endtask : t_read
  task automatic t_write;
    pwr_ok <= 1'b0;
    xfer('{8'h55, 8'h04, 8'h0a, 8'h11, 8'h22, 8'h33, 8'h44});
    check({i_tbd_reader.q[1], 8'(n_wr)}, 16'h6400);
    pwr_ok <= 1'b1;
    xfer('{8'h55, 8'h04, 8'h0a, 8'h11, 8'h22, 8'h33, 8'h44});
    check({i_tbd_reader.q[1], 8'(n_wr)}, 16'h9001);
    check(wdat, 32'h44332211);
    check(wadr, 5'h05);
    wr_lock <= 32'h0000_0020;
    xfer('{8'h55, 8'h04, 8'h0a, 8'h01, 8'h02, 8'h03, 8'h04});
    check({i_tbd_reader.q[1], 8'(n_wr)}, 16'h6201);
    rx_err <= 1'b1;
    xfer('{8'h55, 8'h04, 8'h0c, 8'h01, 8'h02, 8'h03, 8'h04});
    rx_err <= 1'b0;
    check({i_tbd_reader.q[1], 8'(n_wr)}, 16'h6101);
    $display("test eeprom write done");
  endtask : t_write
  task automatic t_desel;
    xfer('{8'hca, 8'h03});
    check(i_tbd_reader.q[0], 8'hca);
    repeat (3) @(posedge mclk);
    check(n_halt, 1);
    send('{8'h0a});
    check(fq.size(), 11);
    $display("test deselect done");
  endtask : t_desel
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_first();
    t_wake();
    t_read();
    t_write();
    t_desel();
    results();
  end
endmodule : tag_block_dispatch_and_eeprom_cmds_test

// >>> test/tbd_reader.sv
// Purpose: reader-side model that takes reply bytes from the tag
// Assumes: one byte taken per edge with TX_VALID and TX_READY high
// Notes:   slow mode offers ready every other cycle
`timescale 1ns/1ps
module tbd_reader (
  input  logic       MCLK,
  input  logic       slow,
  input  logic       TX_VALID,
  input  logic [7:0] TX_DATA,
  input  logic       TX_LAST,
  output logic       TX_READY
);
  logic [7:0] q [$];
  int         n_last = 0;
  logic       tgl    = 1'b0;
  assign TX_READY = slow ? tgl : 1'b1;
  always @(posedge MCLK) begin
    tgl <= ~tgl;
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
      q.push_back(TX_DATA);
      if (TX_LAST === 1'b1) n_last++;
    end
  end
endmodule : tbd_reader
